// file: rtcri_consts.vh
// Behaviour
// - counter keeps running in standby only when keep_in_standby (bit 7) is set
// - prescaler divides slow clock by two to the power of bits 6:3
// - divider and other control writes take effect after two slow cycles
// - drift correction acts only while drift_fix_enable (bit 2) is set
// - counter runs only while counter_enable (bit 0) is set
// - match_sync_pending (status bit 3) high while match_value crosses over
// - limit_sync_pending (status bit 2) high while wrap_limit crosses over
// - count_sync_pending (status bit 1) high while counter_value crosses over
// - control_sync_pending (status bit 0) high while rtc_control crosses over
// - match interrupt requested only when enable bit 1 and its flag set
// - wrap interrupt requested only when enable bit 0 and its flag set
// - flag bit 1 set on counter equal match, cleared by writing one
// - flag bit 0 set on wrap to zero, cleared by writing one
// - one shared 8-bit byte_latch serves every 16-bit register
// - under debug halt, freeze and ignore events unless run_when_halted
// - low byte at base offset, high byte at base plus one
// - tick interval code picks 4 to 32768 slow cycles, code 0 off
// - trim magnitude is cycles added or removed per million slow cycles
// - sign 0 counts slower, sign 1 faster; faster needs divider of two or more
`ifndef RTCRI_CONSTS_VH
`define RTCRI_CONSTS_VH
`define RTCRI_A_CTRL      5'h00
`define RTCRI_A_STAT      5'h01
`define RTCRI_A_IEN       5'h02
`define RTCRI_A_IFLG      5'h03
`define RTCRI_A_LATCH     5'h04
`define RTCRI_A_DBG       5'h05
`define RTCRI_A_TRIM      5'h06
`define RTCRI_A_SRC       5'h07
`define RTCRI_A_CNT       5'h08
`define RTCRI_A_PER       5'h0A
`define RTCRI_A_CMP       5'h0C
`define RTCRI_A_PCTL      5'h10
`define RTCRI_A_PSTAT     5'h11
`define RTCRI_A_PIEN      5'h12
`define RTCRI_A_PFLG      5'h13
`define RTCRI_A_PDBG      5'h15
`define RTCRI_B_STBY      7
`define RTCRI_B_DIV_HI    6
`define RTCRI_B_DIV_LO    3
`define RTCRI_B_FIX       2
`define RTCRI_B_EN        0
`define RTCRI_B_SIGN      7
`define RTCRI_B_CMP       1
`define RTCRI_B_OVF       0
`define RTCRI_S_CTRL      0
`define RTCRI_S_CNT       1
`define RTCRI_S_PER       2
`define RTCRI_S_CMP       3
`define RTCRI_S_PIT       4
`define RTCRI_RST_BYTE    8'h00
`define RTCRI_RST_PER     16'hFFFF
`define RTCRI_RST_WORD    16'h0000
`define RTCRI_SYNC_CYC    2'h2
`define RTCRI_PPM_SPAN    20'hF4240
`define RTCRI_PIT_OFF     4'h0
`define RTCRI_PIT_RSVD    4'hF
`endif

// file: rtcri_regs.v
// The strobed register port was chosen for this implementation.
`include "rtcri_consts.vh"

module rtcri_regs (
   input  wire       clk_sys,
   input  wire       rst_b,
   input  wire [4:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire       rtc_tick,
   input  wire       standby_sleep,
   input  wire       cpu_halted,
   output wire       rtc_irq,
   output wire       tick_irq,
   output reg        wrap_pulse,
   output reg        match_pulse,
   output wire [1:0] clk_source
);

   localparam NSYNC = 5;

   // high byte of a 16-bit pair; its write commits the pair
   function pair_hi;
      input [4:0] addr;
      input [4:0] base;
      begin
         pair_hi = addr == (base + 5'h01);
      end
   endfunction

   // software-side copies
   reg  [7:0]  ctrl_q;
   reg  [1:0]  ien_q;
   reg  [1:0]  iflg_q;
   reg  [7:0]  latch_q;
   reg         dbg_q;
   reg  [7:0]  trim_q;
   reg  [1:0]  src_q;
   reg  [15:0] cnt_wr_q;
   reg  [15:0] per_wr_q;
   reg  [15:0] cmp_wr_q;
   reg  [4:0]  pctl_q;
   reg         pien_q;
   reg         pflg_q;
   reg         pdbg_q;
   reg  [15:0] cnt_view_q;

   // slow-side working copies
   reg  [7:0]  ctrl_act_q;
   reg  [15:0] per_act_q;
   reg  [15:0] cmp_act_q;
   reg  [4:0]  pctl_act_q;
   reg  [15:0] cnt_q;
   reg  [15:0] psc_q;
   reg  [19:0] ppm_acc_q;
   reg  [15:0] pit_cnt_q;

   reg  [1:0]  sync_cnt_q [0:NSYNC-1];
   wire [NSYNC-1:0] sync_busy;
   wire [NSYNC-1:0] sync_done;
   reg  [NSYNC-1:0] sync_start;

   wire       wr_ctrl  = reg_wr && reg_addr == `RTCRI_A_CTRL;
   wire       wr_cnt_h = reg_wr && pair_hi(reg_addr, `RTCRI_A_CNT);
   wire       wr_per_h = reg_wr && pair_hi(reg_addr, `RTCRI_A_PER);
   wire       wr_cmp_h = reg_wr && pair_hi(reg_addr, `RTCRI_A_CMP);
   wire       wr_pctl  = reg_wr && reg_addr == `RTCRI_A_PCTL;

   always @* begin
      sync_start = {NSYNC{1'b0}};
      sync_start[`RTCRI_S_CTRL] = wr_ctrl;
      sync_start[`RTCRI_S_CNT]  = wr_cnt_h;
      sync_start[`RTCRI_S_PER]  = wr_per_h;
      sync_start[`RTCRI_S_CMP]  = wr_cmp_h;
      sync_start[`RTCRI_S_PIT]  = wr_pctl;
   end

   // each crossing waits two slow cycles before the value is applied;
   // a write while busy restarts it, which costs latency, not data
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         always @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               sync_cnt_q[gi] <= 2'h0;
            end else if (sync_start[gi]) begin
               sync_cnt_q[gi] <= `RTCRI_SYNC_CYC;
            end else if (rtc_tick && sync_cnt_q[gi] != 2'h0) begin
               sync_cnt_q[gi] <= sync_cnt_q[gi] - 2'h1;
            end
         end
         assign sync_busy[gi] = sync_cnt_q[gi] != 2'h0;
         assign sync_done[gi] = rtc_tick && sync_cnt_q[gi] == 2'h1;
      end
   endgenerate

   // run qualifiers
   wire halt_frz = cpu_halted && !dbg_q;
   wire pit_frz  = cpu_halted && !pdbg_q;
   wire stby_ok  = !standby_sleep || ctrl_act_q[`RTCRI_B_STBY];
   wire run      = ctrl_act_q[`RTCRI_B_EN] && stby_ok && !halt_frz;
   wire [3:0] div_sel = ctrl_act_q[`RTCRI_B_DIV_HI:`RTCRI_B_DIV_LO];

   // drift correction: spread trim cycles over a million slow cycles
   wire        fix_on   = ctrl_act_q[`RTCRI_B_FIX];
   wire [19:0] acc_sum  = ppm_acc_q + {13'h0000, trim_q[6:0]};
   wire        corr_now = fix_on && acc_sum >= `RTCRI_PPM_SPAN;
   wire        neg_fix  = trim_q[`RTCRI_B_SIGN];
   reg  [1:0]  psc_inc;

   always @* begin
      psc_inc = 2'h1;
      if (corr_now) begin
         if (!neg_fix) begin
            psc_inc = 2'h0;
         end else if (div_sel != 4'h0) begin
            psc_inc = 2'h2;
         end
      end
   end

   wire [15:0] psc_nxt = psc_q + {14'h0000, psc_inc};
   // a prescaled tick is a carry into bit div_sel
   wire        psc_evt = run && rtc_tick &&
                         ((psc_nxt >> div_sel) != (psc_q >> div_sel));

   wire        at_wrap = cnt_q == per_act_q;
   wire [15:0] cnt_nxt = at_wrap ? 16'h0000 : cnt_q + 16'h0001;
   wire        wrap_hit  = psc_evt && at_wrap;
   wire        match_hit = psc_evt && cnt_nxt == cmp_act_q;

   // prescaler and correction accumulator next values
   reg  [15:0] psc_d;
   reg  [19:0] ppm_acc_d;

   always @* begin
      psc_d     = psc_q;
      ppm_acc_d = ppm_acc_q;
      if (run && rtc_tick) begin
         psc_d = psc_nxt;
      end
      if (!fix_on) begin
         ppm_acc_d = 20'h00000;
      end else if (run && rtc_tick) begin
         ppm_acc_d = corr_now ? acc_sum - `RTCRI_PPM_SPAN : acc_sum;
      end
   end

   // counter next value: a committed software write beats a step
   reg  [15:0] cnt_d;

   always @* begin
      cnt_d = cnt_q;
      if (sync_done[`RTCRI_S_CNT]) begin
         cnt_d = cnt_wr_q;
      end else if (psc_evt) begin
         cnt_d = cnt_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         psc_q     <= `RTCRI_RST_WORD;
         ppm_acc_q <= 20'h00000;
      end else begin
         psc_q     <= psc_d;
         ppm_acc_q <= ppm_acc_d;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_act_q  <= `RTCRI_RST_BYTE;
         per_act_q   <= `RTCRI_RST_PER;
         cmp_act_q   <= `RTCRI_RST_WORD;
         pctl_act_q  <= 5'h00;
         cnt_q       <= `RTCRI_RST_WORD;
         wrap_pulse  <= 1'b0;
         match_pulse <= 1'b0;
      end else begin
         if (sync_done[`RTCRI_S_CTRL]) begin
            ctrl_act_q <= ctrl_q;
         end
         if (sync_done[`RTCRI_S_PER]) begin
            per_act_q <= per_wr_q;
         end
         if (sync_done[`RTCRI_S_CMP]) begin
            cmp_act_q <= cmp_wr_q;
         end
         if (sync_done[`RTCRI_S_PIT]) begin
            pctl_act_q <= pctl_q;
         end
         cnt_q <= cnt_d;
         wrap_pulse  <= wrap_hit;
         match_pulse <= match_hit;
      end
   end

   // periodic tick: own counter, runs in every sleep mode
   wire [3:0]  pit_sel = pctl_act_q[4:1];
   wire        pit_run = pctl_act_q[0] && !pit_frz && pit_sel != `RTCRI_PIT_OFF
                         && pit_sel != `RTCRI_PIT_RSVD;
   wire [15:0] pit_mask = (16'h0002 << pit_sel) - 16'h0001;
   wire        pit_hit  = pit_run && rtc_tick &&
                          (pit_cnt_q & pit_mask) == pit_mask;

   // the tick counter restarts from zero whenever enable bit 0 is clear,
   // so the first interval after enabling is always a full one
   reg  [15:0] pit_cnt_d;

   always @* begin
      pit_cnt_d = pit_cnt_q;
      if (!pctl_act_q[0]) begin
         pit_cnt_d = `RTCRI_RST_WORD;
      end else if (pit_run && rtc_tick) begin
         pit_cnt_d = pit_cnt_q + 16'h0001;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pit_cnt_q <= `RTCRI_RST_WORD;
      end else begin
         pit_cnt_q <= pit_cnt_d;
      end
   end

   // sampled counter copy for software
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_view_q <= `RTCRI_RST_WORD;
      end else begin
         cnt_view_q <= cnt_q;
      end
   end

   wire w1c_flg  = reg_wr && reg_addr == `RTCRI_A_IFLG;
   wire w1c_pflg = reg_wr && reg_addr == `RTCRI_A_PFLG;
   wire rd_lo16  = reg_rd && (reg_addr == `RTCRI_A_CNT ||
                   reg_addr == `RTCRI_A_PER || reg_addr == `RTCRI_A_CMP);

   // flag next values: the hardware set wins over a same-cycle clear,
   // so an event landing on the clearing write is never lost
   reg  [1:0]  iflg_d;
   reg         pflg_d;
   wire [1:0]  iflg_clr = w1c_flg ? reg_wdata[1:0] : 2'h0;
   wire        pflg_clr = w1c_pflg && reg_wdata[0];

   always @* begin
      iflg_d = iflg_q & ~iflg_clr;
      if (match_hit) begin
         iflg_d[`RTCRI_B_CMP] = 1'b1;
      end
      if (wrap_hit) begin
         iflg_d[`RTCRI_B_OVF] = 1'b1;
      end
      pflg_d = pflg_q && !pflg_clr;
      if (pit_hit) begin
         pflg_d = 1'b1;
      end
   end

   // byte_latch next value; a write beats a same-cycle read capture
   reg  [7:0]  latch_d;

   always @* begin
      latch_d = latch_q;
      if (rd_lo16) begin
         case (reg_addr)
            `RTCRI_A_CNT: latch_d = cnt_view_q[15:8];
            `RTCRI_A_PER: latch_d = per_wr_q[15:8];
            default:      latch_d = cmp_wr_q[15:8];
         endcase
      end
      if (reg_wr) begin
         case (reg_addr)
            `RTCRI_A_LATCH: latch_d = reg_wdata;
            `RTCRI_A_CNT,
            `RTCRI_A_PER,
            `RTCRI_A_CMP:   latch_d = reg_wdata;
            default:        latch_d = latch_q;
         endcase
      end
   end

   // software write side
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q   <= `RTCRI_RST_BYTE;
         ien_q    <= 2'h0;
         iflg_q   <= 2'h0;
         latch_q  <= `RTCRI_RST_BYTE;
         dbg_q    <= 1'b0;
         trim_q   <= `RTCRI_RST_BYTE;
         src_q    <= 2'h0;
         cnt_wr_q <= `RTCRI_RST_WORD;
         per_wr_q <= `RTCRI_RST_PER;
         cmp_wr_q <= `RTCRI_RST_WORD;
         pctl_q   <= 5'h00;
         pien_q   <= 1'b0;
         pflg_q   <= 1'b0;
         pdbg_q   <= 1'b0;
      end else begin
         iflg_q  <= iflg_d;
         pflg_q  <= pflg_d;
         latch_q <= latch_d;
         if (reg_wr) begin
            case (reg_addr)
               `RTCRI_A_CTRL:  ctrl_q  <= reg_wdata & 8'hFD;
               `RTCRI_A_IEN:   ien_q   <= reg_wdata[1:0];
               `RTCRI_A_DBG:   dbg_q   <= reg_wdata[0];
               `RTCRI_A_TRIM:  trim_q  <= reg_wdata;
               `RTCRI_A_SRC:   src_q   <= reg_wdata[1:0];
               `RTCRI_A_CNT + 5'h01: cnt_wr_q <= {reg_wdata, latch_q};
               `RTCRI_A_PER + 5'h01: per_wr_q <= {reg_wdata, latch_q};
               `RTCRI_A_CMP + 5'h01: cmp_wr_q <= {reg_wdata, latch_q};
               `RTCRI_A_PCTL:  pctl_q  <= {reg_wdata[6:3], reg_wdata[0]};
               `RTCRI_A_PIEN:  pien_q  <= reg_wdata[0];
               `RTCRI_A_PDBG:  pdbg_q  <= reg_wdata[0];
               default: ;
            endcase
         end
      end
   end

   // read mux; result appears the cycle after the strobe
   reg [7:0] rd_mux;

   always @* begin
      rd_mux = 8'h00;
      case (reg_addr)
         `RTCRI_A_CTRL:  rd_mux = ctrl_q;
         `RTCRI_A_STAT:  rd_mux = {4'h0,
                                   sync_busy[`RTCRI_S_CMP],
                                   sync_busy[`RTCRI_S_PER],
                                   sync_busy[`RTCRI_S_CNT],
                                   sync_busy[`RTCRI_S_CTRL]};
         `RTCRI_A_IEN:   rd_mux = {6'h00, ien_q};
         `RTCRI_A_IFLG:  rd_mux = {6'h00, iflg_q};
         `RTCRI_A_LATCH: rd_mux = latch_q;
         `RTCRI_A_DBG:   rd_mux = {7'h00, dbg_q};
         `RTCRI_A_TRIM:  rd_mux = trim_q;
         `RTCRI_A_SRC:   rd_mux = {6'h00, src_q};
         `RTCRI_A_CNT:   rd_mux = cnt_view_q[7:0];
         `RTCRI_A_CNT + 5'h01: rd_mux = latch_q;
         `RTCRI_A_PER:   rd_mux = per_wr_q[7:0];
         `RTCRI_A_PER + 5'h01: rd_mux = latch_q;
         `RTCRI_A_CMP:   rd_mux = cmp_wr_q[7:0];
         `RTCRI_A_CMP + 5'h01: rd_mux = latch_q;
         `RTCRI_A_PCTL:  rd_mux = {1'b0, pctl_q[4:1], 2'h0, pctl_q[0]};
         `RTCRI_A_PSTAT: rd_mux = {7'h00, sync_busy[`RTCRI_S_PIT]};
         `RTCRI_A_PIEN:  rd_mux = {7'h00, pien_q};
         `RTCRI_A_PFLG:  rd_mux = {7'h00, pflg_q};
         `RTCRI_A_PDBG:  rd_mux = {7'h00, pdbg_q};
         default:        rd_mux = 8'h00;
      endcase
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   assign rtc_irq = (ien_q[`RTCRI_B_CMP] && iflg_q[`RTCRI_B_CMP]) ||
                    (ien_q[`RTCRI_B_OVF] && iflg_q[`RTCRI_B_OVF]);
   assign tick_irq   = pien_q && pflg_q;
   assign clk_source = src_q;

endmodule // rtcri_regs

// file: rtcri_regs_properties.sv
module rtcri_checker (
   input wire       clk_sys,
   input wire       rst_b,
   input wire [4:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   input wire       rtc_tick,
   input wire       standby_sleep,
   input wire       cpu_halted,
   input wire       rtc_irq,
   input wire       tick_irq,
   input wire       wrap_pulse,
   input wire       match_pulse,
   input wire [1:0] clk_source
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   // tick-free gap and read, so fewer than two slow cycles can pass
   sequence s_cross(logic [4:0] wa);
      reg_wr && reg_addr == wa ##1 !rtc_tick
         ##1 reg_rd && reg_addr == 5'h01 && !rtc_tick;
   endsequence
   property p_rsvd_zero;
      reg_rd && (reg_addr inside {5'h0E, 5'h0F, 5'h14} || reg_addr > 5'h15)
         |=> reg_rdata == 8'h00;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("rsvd");
   property p_ctl_busy;
      s_cross(5'h00) |=> reg_rdata[0];
   endproperty
   a_ctl_busy: assert property (p_ctl_busy) else $error("ctl busy");
   property p_cnt_busy;
      s_cross(5'h09) |=> reg_rdata[1];
   endproperty
   a_cnt_busy: assert property (p_cnt_busy) else $error("cnt busy");
   property p_per_busy;
      s_cross(5'h0B) |=> reg_rdata[2];
   endproperty
   a_per_busy: assert property (p_per_busy) else $error("per busy");
   property p_cmp_busy;
      s_cross(5'h0D) |=> reg_rdata[3];
   endproperty
   a_cmp_busy: assert property (p_cmp_busy) else $error("cmp busy");
   property p_ien_off;
      reg_wr && reg_addr == 5'h02 && reg_wdata[1:0] == 2'h0 |=> !rtc_irq;
   endproperty
   a_ien_off: assert property (p_ien_off) else $error("ien");
   // a tick in the write cycle may set a flag again: set beats clear
   property p_w1c;
      reg_wr && reg_addr == 5'h03 && reg_wdata[1:0] == 2'h3 && !rtc_tick
         |=> !rtc_irq;
   endproperty
   a_w1c: assert property (p_w1c) else $error("w1c");
   property p_wrap_src;
      wrap_pulse |-> $past(rtc_tick) || $past(rtc_tick, 2);
   endproperty
   a_wrap_src: assert property (p_wrap_src) else $error("wrap");
   property p_latch;
      reg_wr && reg_addr == 5'h04 ##1 !reg_wr && !reg_rd
         ##1 reg_rd && reg_addr == 5'h04 |=> reg_rdata == $past(reg_wdata, 3);
   endproperty
   a_latch: assert property (p_latch) else $error("latch");
   c_wrap: cover property (wrap_pulse);
   c_match: cover property (match_pulse);
   c_tick: cover property (tick_irq);
endmodule // rtcri_checker

bind rtcri_regs rtcri_checker u_chk (
   .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .rtc_tick(rtc_tick), .standby_sleep(standby_sleep),
   .cpu_halted(cpu_halted), .rtc_irq(rtc_irq), .tick_irq(tick_irq),
   .wrap_pulse(wrap_pulse), .match_pulse(match_pulse),
   .clk_source(clk_source));

// file: test_rtc_register_interface.sv
module test_rtc_register_interface;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys = 1'b0;
   logic       rst_b = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       rtc_tick = 1'b0;
   logic       standby_sleep = 1'b0;
   logic       cpu_halted = 1'b0;
   logic [2:0] tcnt = 3'h0;
   logic [7:0] r, d, e;
   logic [4:0] ua;
   wire  [7:0] reg_rdata;
   wire  [1:0] clk_source;
   wire        rtc_irq, tick_irq, wrap_pulse, match_pulse;
   int         num_errors = 0;
   int         cmp_count = 0;
   int         i;
   always #20 clk_sys = ~clk_sys;
   // slow clock as a strobe every eighth cycle
   always @(posedge clk_sys) begin
      tcnt <= tcnt + 3'h1;
      rtc_tick <= (tcnt == 3'h7);
   end
   rtcri_regs u_rtcri_regs (
      .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rtc_tick(rtc_tick), .standby_sleep(standby_sleep),
      .cpu_halted(cpu_halted), .rtc_irq(rtc_irq), .tick_irq(tick_irq),
      .wrap_pulse(wrap_pulse), .match_pulse(match_pulse),
      .clk_source(clk_source));
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] x);
      cmp_count++;
      if (g !== x) begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic chk1(input logic g, input logic x);
      chk8({7'h00, g}, {7'h00, x});
   endtask
   task automatic idle;
      for (i = 0; i < 40; i++) begin
         rd(5'h01, r);
         if (r[3:0] === 4'h0) break;
      end
      chk1(r[3:0] === 4'h0, 1'b1);
   endtask
   task automatic wwrap;
      @(posedge clk_sys);
      for (i = 0; i < 400 && wrap_pulse !== 1'b1; i++) @(posedge clk_sys);
   endtask
   // 22 cycles: two or three slow ticks, never a whole wrap of four
   task automatic frz(input logic x);
      logic [7:0] a, b;
      rd(5'h08, a);
      repeat (20) @(posedge clk_sys);
      rd(5'h08, b);
      chk1(a === b, x);
   endtask
   task automatic summarize;
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      i = $urandom(32'hB3A5);
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int a = 0; a < 32; a++) begin
         rd(5'(a), r);
         chk8(r, (a == 10 || a == 11) ? 8'hFF : 8'h00);
      end
      for (int k = 0; k < 4; k++) begin
         ua = (k == 0) ? 5'h0E : 5'h16 + 5'($urandom_range(9));
         wr(ua, 8'($urandom()));
         rd(ua, r);
         chk8(r, 8'h00);
      end
      $display("reset and reserved test done");
      d = 8'($urandom());
      e = 8'($urandom());
      wr(5'h04, d);
      rd(5'h04, r);
      chk8(r, d);
      wr(5'h0C, d);
      wr(5'h0D, e);
      idle;
      rd(5'h0C, r);
      chk8(r, d);
      rd(5'h0D, r);
      chk8(r, e);
      $display("pairing test done");
      wr(5'h0A, 8'h03);
      wr(5'h0B, 8'h00);
      idle;
      wr(5'h08, 8'h00);
      wr(5'h09, 8'h00);
      idle;
      wr(5'h02, 8'h01);
      wr(5'h00, 8'h01);
      rd(5'h01, r);
      chk1(r[0], 1'b1);
      idle;
      wwrap;
      #1 chk1(rtc_irq, 1'b1);
      wr(5'h00, 8'h00);
      idle;
      wr(5'h03, 8'h03);
      #1 chk1(rtc_irq, 1'b0);
      $display("wrap test done");
      wr(5'h0C, 8'h02);
      wr(5'h0D, 8'h00);
      wr(5'h02, 8'h02);
      wr(5'h00, 8'h01);
      idle;
      for (i = 0; i < 400 && match_pulse !== 1'b1; i++) @(posedge clk_sys);
      #1 chk1(rtc_irq, 1'b1);
      wr(5'h02, 8'h00);
      #1 chk1(rtc_irq, 1'b0);
      $display("match test done");
      // divide by two: 8 cycles a tick, 2 ticks a step, 4 steps a wrap
      wr(5'h00, 8'h09);
      idle;
      wwrap;
      for (i = 1; i < 200; i++) begin
         @(posedge clk_sys);
         if (wrap_pulse === 1'b1) break;
      end
      chk8(8'(i), 8'h40);
      @(posedge clk_sys);
      cpu_halted <= 1'b1;
      frz(1'b1);
      wr(5'h05, 8'h01);
      frz(1'b0);
      wr(5'h05, 8'h00);
      cpu_halted <= 1'b0;
      standby_sleep <= 1'b1;
      frz(1'b1);
      wr(5'h00, 8'h89);
      idle;
      frz(1'b0);
      standby_sleep <= 1'b0;
      wr(5'h00, 8'h08);
      idle;
      frz(1'b1);
      $display("freeze test done");
      wr(5'h12, 8'h01);
      wr(5'h10, 8'h09);
      for (i = 0; i < 400 && tick_irq !== 1'b1; i++) @(posedge clk_sys);
      #1 chk1(tick_irq, 1'b1);
      $display("tick test done");
      d = 8'($urandom());
      wr(5'h07, d);
      #1 chk8({6'h00, clk_source}, {6'h00, d[1:0]});
      rd(5'h07, r);
      chk8(r, {6'h00, d[1:0]});
      wr(5'h06, d);
      rd(5'h06, r);
      chk8(r, d);
      $display("source and trim test done");
      summarize;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      summarize;
   end
endmodule // test_rtc_register_interface
